/* hdl/osp_osc_ctrl.sv */
// Notes on behaviour
// - One of eight clock source modes runs, picked by the configuration word.
// - RC clock-out mode: RC clocks the core, output pin drives Fosc/4.
// - RC pins-free mode: RC clocks the core, output pin is general I/O.
// - Internal clock-out mode: input pin is I/O, output pin drives Fosc/4.
// - Internal pins-free mode: both pins are I/O, internal oscillator clocks core.
// - External clock mode: input pin clocks the core, output pin is I/O.
// - Resonator modes set amplifier gain high, medium or lowest power.
// - Internal path offers eight frequencies, at most 16 MHz, two sources.
// - Frequency select drives a postscaler dividing by one, two, four or eight.
// - High range bit picks the 16 MHz source, else the 500 kHz one.
// - High range: codes 11, 10, 01, 00 give 16, 8, 4, 2 MHz.
// - Low range: codes 11, 10, 01, 00 give 500, 250, 125, 62.5 kHz.
// - Every reset loads the frequency select with binary 10.
// - A new frequency select value needs no start-up delay.
// - Bit 3 reads one once the fast oscillator locked within 2 percent.
// - Bit 2 reads one once the fast oscillator reached 0.5 percent accuracy.
// - Bits 7 to 6 and 1 to 0 read zero; writes ignored.
`default_nettype none

module osp_osc_ctrl
  import osp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] cfg_clock_source,
  input wire logic cfg_high_range,
  input wire logic int_osc_tick,
  input wire logic rc_osc_tick,
  input wire logic resonator_tick,
  input wire logic fast_osc_lock_raw,
  input wire logic fast_osc_stable_raw,
  input wire logic osc_in_i,
  input wire logic osc_out_i,
  input wire osp_pin_t gpio_in_drive,
  input wire osp_pin_t gpio_out_drive,
  output osp_pin_t osc_in_pin,
  output osp_pin_t osc_out_pin,
  output logic osc_in_gpio,
  output logic osc_out_gpio,
  output logic sys_clk_tick,
  output logic [1:0] amp_gain,
  output logic amp_enable,
  output logic int_osc_enable,
  output logic int_range_high,
  output logic irq
);

  osp_ctrl_state_t st;
  osp_ctrl_state_t next_st;

  logic post_tick;
  logic [1:0] post_sel;
  logic clkout_level;
  logic setup;
  logic wr;
  logic addr_hit;
  logic [31:0] rd_word;
  logic fosc_tick;
  logic [1:0] events;
  logic [1:0] clear_mask;
  logic internal_mode;

  // The postscaler only sees source ticks while an internal mode is active.
  osp_postscaler u_post (
    .pclk(pclk),
    .presetn(presetn),
    .src_tick(int_osc_tick && st.int_osc_enable),
    .sel(st.ifs),
    .tick(post_tick),
    .active_sel(post_sel)
  );

  osp_clkout_div4 u_div4 (
    .pclk(pclk),
    .presetn(presetn),
    .fosc_tick(st.sys_tick),
    .clk_out(clkout_level)
  );

  always_comb begin
    setup = psel && !penable;
    wr = psel && penable && st.pready && pwrite;
    addr_hit = (paddr == ADDR_OSC_CTRL) || (paddr == ADDR_INT_STATUS)
      || (paddr == ADDR_INT_MASK) || (paddr == ADDR_CLK_INFO);
    rd_word = 32'h0000_0000;
    case (paddr)
      ADDR_OSC_CTRL: begin
        rd_word[IFS_MSB:IFS_LSB] = st.ifs;
        rd_word[LOCK_BIT] = st.lock_s2;
        rd_word[STABLE_BIT] = st.stab_s2;
      end
      ADDR_INT_STATUS: begin
        rd_word[1:0] = st.int_status;
      end
      ADDR_INT_MASK: begin
        rd_word[1:0] = st.int_mask;
      end
      ADDR_CLK_INFO: begin
        rd_word[INFO_MODE_MSB:0] = st.mode;
        rd_word[INFO_RANGE_BIT] = st.high_range;
        rd_word[INFO_VALID_BIT] = st.cfg_valid;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  always_comb begin
    internal_mode = (st.mode == MODE_INT_PINS_FREE) || (st.mode == MODE_INT_CLOCK_OUT);
    case (st.mode)
      MODE_RC_CLOCK_OUT, MODE_RC_PINS_FREE: begin
        fosc_tick = rc_osc_tick;
      end
      MODE_INT_CLOCK_OUT, MODE_INT_PINS_FREE: begin
        fosc_tick = post_tick;
      end
      MODE_EXT_CLOCK: begin
        fosc_tick = st.in_s2 && !st.in_q;
      end
      default: begin
        fosc_tick = resonator_tick;
      end
    endcase
    events = 2'h0;
    events[EV_LOCK_BIT] = st.lock_s2 && !st.lock_q;
    events[EV_STABLE_BIT] = st.stab_s2 && !st.stab_q;
    clear_mask = (wr && paddr == ADDR_INT_STATUS) ? pwdata[1:0] : 2'h0;
  end

  always_comb begin
    next_st = st;

    // The strap pins are caught once, on the first edge after reset release.
    if (!st.cfg_valid) begin
      next_st.cfg_valid = 1'b1;
      next_st.mode = cfg_clock_source;
      next_st.high_range = cfg_high_range;
    end

    next_st.lock_s1 = fast_osc_lock_raw;
    next_st.lock_s2 = st.lock_s1;
    next_st.lock_q = st.lock_s2;
    next_st.stab_s1 = fast_osc_stable_raw;
    next_st.stab_s2 = st.stab_s1;
    next_st.stab_q = st.stab_s2;
    next_st.in_s1 = osc_in_i;
    next_st.in_s2 = st.in_s1;
    next_st.in_q = st.in_s2;
    next_st.out_s1 = osc_out_i;
    next_st.out_s2 = st.out_s1;
    next_st.in_gpio = st.in_s2;
    next_st.out_gpio = st.out_s2;

    // APB slave: one access cycle per transfer, unmapped addresses get an error.
    next_st.pready = setup;
    next_st.pslverr = setup && !addr_hit;
    next_st.prdata = (setup && !pwrite) ? rd_word : 32'h0000_0000;
    if (wr && paddr == ADDR_OSC_CTRL) begin
      next_st.ifs = pwdata[IFS_MSB:IFS_LSB];
    end
    if (wr && paddr == ADDR_INT_MASK) begin
      next_st.int_mask = pwdata[1:0];
    end

    // A new event wins over a simultaneous write-one clear.
    next_st.int_status = (st.int_status & ~clear_mask) | events;
    next_st.irq = |(next_st.int_status & next_st.int_mask);

    next_st.sys_tick = st.cfg_valid && fosc_tick;
    next_st.int_osc_enable = st.cfg_valid && internal_mode;
    next_st.range_high = st.high_range;

    next_st.in_pin = '0;
    next_st.out_pin = '0;
    next_st.amp_enable = 1'b0;
    next_st.amp_gain = GAIN_OFF;
    if (st.cfg_valid) begin
      case (st.mode)
        MODE_RC_CLOCK_OUT: begin
          next_st.out_pin = '{o: clkout_level, oe: 1'b1};
        end
        MODE_RC_PINS_FREE: begin
          next_st.out_pin = gpio_out_drive;
        end
        MODE_INT_CLOCK_OUT: begin
          next_st.in_pin = gpio_in_drive;
          next_st.out_pin = '{o: clkout_level, oe: 1'b1};
        end
        MODE_INT_PINS_FREE: begin
          next_st.in_pin = gpio_in_drive;
          next_st.out_pin = gpio_out_drive;
        end
        MODE_EXT_CLOCK: begin
          next_st.out_pin = gpio_out_drive;
        end
        MODE_HIGH_GAIN_RES: begin
          next_st.amp_enable = 1'b1;
          next_st.amp_gain = GAIN_HIGH;
        end
        MODE_MEDIUM_GAIN_RES: begin
          next_st.amp_enable = 1'b1;
          next_st.amp_gain = GAIN_MEDIUM;
        end
        default: begin
          next_st.amp_enable = 1'b1;
          next_st.amp_gain = GAIN_LOW;
        end
      endcase
    end
  end

  // Reset restores the frequency select to its default on every reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= CTRL_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign osc_in_pin = st.in_pin;
  assign osc_out_pin = st.out_pin;
  assign osc_in_gpio = st.in_gpio;
  assign osc_out_gpio = st.out_gpio;
  assign sys_clk_tick = st.sys_tick;
  assign amp_gain = st.amp_gain;
  assign amp_enable = st.amp_enable;
  assign int_osc_enable = st.int_osc_enable;
  assign int_range_high = st.range_high;
  assign irq = st.irq;

  // The postscaler only counts in the internal modes, so adoption is only checked there.
  property p_ifs_write;
    @(posedge pclk) disable iff (!presetn)
      (wr && paddr == ADDR_OSC_CTRL && st.int_osc_enable) |=>
        (st.ifs == $past(pwdata[IFS_MSB:IFS_LSB])) ##[8:40] (post_sel == st.ifs);
  endproperty
  a_ifs_write: assert property (p_ifs_write) else $error("frequency select not applied");

  property p_ctrl_reserved;
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && paddr == ADDR_OSC_CTRL) |=>
        (prdata[31:6] == 26'h0 && prdata[1:0] == 2'h0 && pready);
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("reserved bits read nonzero");

  property p_lock_read;
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && paddr == ADDR_OSC_CTRL) |=> (prdata[LOCK_BIT] == $past(st.lock_s2));
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock status misread");

  property p_stable_read;
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && paddr == ADDR_OSC_CTRL) |=> (prdata[STABLE_BIT] == $past(st.stab_s2));
  endproperty
  a_stable_read: assert property (p_stable_read) else $error("stable status misread");

  property p_rc_clock_out;
    @(posedge pclk) disable iff (!presetn)
      (st.cfg_valid && st.mode == MODE_RC_CLOCK_OUT) |=> (osc_out_pin.oe && !osc_in_pin.oe);
  endproperty
  a_rc_clock_out: assert property (p_rc_clock_out) else $error("clock out not driven");

  property p_rc_pins_free;
    @(posedge pclk) disable iff (!presetn)
      (st.cfg_valid && st.mode == MODE_RC_PINS_FREE) |=> (osc_out_pin == $past(gpio_out_drive));
  endproperty
  a_rc_pins_free: assert property (p_rc_pins_free) else $error("output pin not general I/O");

  property p_int_clock_out;
    @(posedge pclk) disable iff (!presetn)
      (st.cfg_valid && st.mode == MODE_INT_CLOCK_OUT) |=>
        (osc_in_pin == $past(gpio_in_drive) && osc_out_pin.oe && int_osc_enable);
  endproperty
  a_int_clock_out: assert property (p_int_clock_out) else $error("internal clock out pins wrong");

  property p_int_pins_free;
    @(posedge pclk) disable iff (!presetn)
      (st.cfg_valid && st.mode == MODE_INT_PINS_FREE) |=>
        (osc_out_pin == $past(gpio_out_drive) && osc_in_pin == $past(gpio_in_drive));
  endproperty
  a_int_pins_free: assert property (p_int_pins_free) else $error("pins not released");

  property p_ext_clock;
    @(posedge pclk) disable iff (!presetn)
      (st.cfg_valid && st.mode == MODE_EXT_CLOCK && st.in_s2 && !st.in_q) |=>
        (sys_clk_tick && !osc_in_pin.oe);
  endproperty
  a_ext_clock: assert property (p_ext_clock) else $error("external clock edge lost");

  property p_gain;
    @(posedge pclk) disable iff (!presetn)
      (st.cfg_valid && st.mode == MODE_HIGH_GAIN_RES) |=> (amp_gain == GAIN_HIGH && amp_enable);
  endproperty
  a_gain: assert property (p_gain) else $error("resonator gain wrong");

  property p_event_sticky;
    @(posedge pclk) disable iff (!presetn)
      events[EV_LOCK_BIT] |=> (st.int_status[EV_LOCK_BIT] && (irq == st.int_mask[EV_LOCK_BIT] || irq));
  endproperty
  a_event_sticky: assert property (p_event_sticky) else $error("lock event lost");

  property p_stable_event;
    @(posedge pclk) disable iff (!presetn)
      events[EV_STABLE_BIT] |=> st.int_status[EV_STABLE_BIT];
  endproperty
  a_stable_event: assert property (p_stable_event) else $error("stable event lost");

  property p_mode_capture;
    @(posedge pclk) disable iff (!presetn)
      (!st.cfg_valid) |=> (st.cfg_valid && st.mode == $past(cfg_clock_source));
  endproperty
  a_mode_capture: assert property (p_mode_capture) else $error("clock mode not caught");

  property p_range_level;
    @(posedge pclk) disable iff (!presetn)
      st.cfg_valid |=> (int_range_high == $past(st.high_range));
  endproperty
  a_range_level: assert property (p_range_level) else $error("range level wrong");

  property p_ifs_reset;
    @(posedge pclk) disable iff (!presetn)
      (!st.cfg_valid) |-> (st.ifs == IFS_RESET);
  endproperty
  a_ifs_reset: assert property (p_ifs_reset) else $error("select not at reset value");

  property p_rc_tick;
    @(posedge pclk) disable iff (!presetn)
      (st.cfg_valid && (st.mode == MODE_RC_CLOCK_OUT || st.mode == MODE_RC_PINS_FREE)
        && rc_osc_tick) |=> sys_clk_tick;
  endproperty
  a_rc_tick: assert property (p_rc_tick) else $error("RC tick lost");

endmodule : osp_osc_ctrl

`default_nettype wire

/* hdl/osp_pkg.sv */
`default_nettype none

package osp_pkg;

  // Register byte addresses on the APB.
  localparam logic [11:0] ADDR_OSC_CTRL = 12'h000;
  localparam logic [11:0] ADDR_INT_STATUS = 12'h004;
  localparam logic [11:0] ADDR_INT_MASK = 12'h008;
  localparam logic [11:0] ADDR_CLK_INFO = 12'h00c;

  // Oscillator control register fields.
  localparam int IFS_MSB = 5;
  localparam int IFS_LSB = 4;
  localparam int LOCK_BIT = 3;
  localparam int STABLE_BIT = 2;
  localparam logic [1:0] IFS_RESET = 2'h2;

  // Interrupt status and mask layout.
  localparam int EV_LOCK_BIT = 0;
  localparam int EV_STABLE_BIT = 1;

  // Clock info register fields.
  localparam int INFO_MODE_MSB = 2;
  localparam int INFO_RANGE_BIT = 3;
  localparam int INFO_VALID_BIT = 4;

  // Clock source codes of the configuration word.
  localparam logic [2:0] MODE_LOW_POWER_RES = 3'h0;
  localparam logic [2:0] MODE_MEDIUM_GAIN_RES = 3'h1;
  localparam logic [2:0] MODE_HIGH_GAIN_RES = 3'h2;
  localparam logic [2:0] MODE_EXT_CLOCK = 3'h3;
  localparam logic [2:0] MODE_INT_PINS_FREE = 3'h4;
  localparam logic [2:0] MODE_INT_CLOCK_OUT = 3'h5;
  localparam logic [2:0] MODE_RC_PINS_FREE = 3'h6;
  localparam logic [2:0] MODE_RC_CLOCK_OUT = 3'h7;

  // Resonator amplifier gain codes.
  localparam logic [1:0] GAIN_OFF = 2'h0;
  localparam logic [1:0] GAIN_LOW = 2'h1;
  localparam logic [1:0] GAIN_MEDIUM = 2'h2;
  localparam logic [1:0] GAIN_HIGH = 2'h3;

  // Postscaler phase counter wraps here, where every divided phase ends together.
  localparam logic [2:0] POST_WRAP = 3'h7;

  typedef struct packed {
    logic o;
    logic oe;
  } osp_pin_t;

  typedef struct packed {
    logic [2:0] cnt;
    logic [1:0] active_sel;
    logic tick;
  } osp_post_state_t;

  localparam osp_post_state_t POST_RESET = '{cnt: 3'h0, active_sel: IFS_RESET, tick: 1'b0};

  typedef struct packed {
    logic half;
    logic clk_out;
  } osp_div4_state_t;

  typedef struct packed {
    logic cfg_valid;
    logic [2:0] mode;
    logic high_range;
    logic [1:0] ifs;
    logic lock_s1;
    logic lock_s2;
    logic lock_q;
    logic stab_s1;
    logic stab_s2;
    logic stab_q;
    logic in_s1;
    logic in_s2;
    logic in_q;
    logic out_s1;
    logic out_s2;
    logic [1:0] int_status;
    logic [1:0] int_mask;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    osp_pin_t in_pin;
    osp_pin_t out_pin;
    logic in_gpio;
    logic out_gpio;
    logic sys_tick;
    logic [1:0] amp_gain;
    logic amp_enable;
    logic int_osc_enable;
    logic range_high;
  } osp_ctrl_state_t;

  localparam osp_ctrl_state_t CTRL_RESET = '{ifs: IFS_RESET, default: '0};

endpackage : osp_pkg

`default_nettype wire

/* hdl/osp_postscaler.sv */
`default_nettype none

module osp_postscaler
  import osp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic src_tick,
  input wire logic [1:0] sel,
  output logic tick,
  output logic [1:0] active_sel
);

  osp_post_state_t st;
  osp_post_state_t next_st;

  function automatic logic [2:0] div_mask(input logic [1:0] code);
    case (code)
      2'h3: div_mask = 3'h0;
      2'h2: div_mask = 3'h1;
      2'h1: div_mask = 3'h3;
      default: div_mask = 3'h7;
    endcase
  endfunction : div_mask

  // A new selection is only adopted at the wrap of the phase counter, so the
  // old output has just finished a whole period; this costs up to eight source
  // periods of latency but never shortens a pulse.
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (src_tick) begin
      next_st.cnt = st.cnt + 3'h1;
      next_st.tick = (st.cnt & div_mask(st.active_sel)) == div_mask(st.active_sel);
      if (st.cnt == POST_WRAP) begin
        next_st.active_sel = sel;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= POST_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
  assign active_sel = st.active_sel;

  property p_switch_at_wrap;
    @(posedge pclk) disable iff (!presetn)
      (st.active_sel != $past(st.active_sel)) |-> $past(src_tick && st.cnt == POST_WRAP);
  endproperty
  a_switch_at_wrap: assert property (p_switch_at_wrap) else $error("postscaler switched mid period");

  property p_div_by_one;
    @(posedge pclk) disable iff (!presetn)
      (src_tick && st.active_sel == 2'h3) |=> tick;
  endproperty
  a_div_by_one: assert property (p_div_by_one) else $error("divide by one missed a tick");

endmodule : osp_postscaler

`default_nettype wire

/* hdl/osp_clkout_div4.sv */
`default_nettype none

module osp_clkout_div4
  import osp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fosc_tick,
  output logic clk_out
);

  osp_div4_state_t st;
  osp_div4_state_t next_st;

  // The output toggles on every second oscillator tick, giving one full
  // period per four oscillator periods.
  always_comb begin
    next_st = st;
    if (fosc_tick) begin
      next_st.half = !st.half;
      if (st.half) begin
        next_st.clk_out = !st.clk_out;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign clk_out = st.clk_out;

  property p_toggle_on_second;
    @(posedge pclk) disable iff (!presetn)
      (st.clk_out != $past(st.clk_out)) |-> $past(fosc_tick && st.half);
  endproperty
  a_toggle_on_second: assert property (p_toggle_on_second) else $error("clock out toggled early");

endmodule : osp_clkout_div4

`default_nettype wire

/* verif/osp_osc_ctrl_bench.sv */
`default_nettype none

`define OSP_CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end

module osp_osc_ctrl_bench
  import osp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] cfg_clock_source;
  logic cfg_high_range, int_osc_tick, rc_osc_tick, resonator_tick;
  logic lock_raw, stable_raw, ext_clk, osc_in_i, osc_out_i;
  osp_pin_t gpio_in_drive, gpio_out_drive, osc_in_pin, osc_out_pin;
  logic osc_in_gpio, osc_out_gpio, sys_clk_tick, amp_enable, int_osc_enable;
  logic int_range_high, irq;
  logic [1:0] amp_gain;
  int err_total, num_checks;

  // The pins resolve from the block's drive; an undriven output pin floats up.
  assign osc_in_i = osc_in_pin.oe ? osc_in_pin.o : ext_clk;
  assign osc_out_i = osc_out_pin.oe ? osc_out_pin.o : 1'b1;

  osp_osc_ctrl i_osp_osc_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cfg_clock_source(cfg_clock_source), .cfg_high_range(cfg_high_range),
    .int_osc_tick(int_osc_tick), .rc_osc_tick(rc_osc_tick), .resonator_tick(resonator_tick),
    .fast_osc_lock_raw(lock_raw), .fast_osc_stable_raw(stable_raw),
    .osc_in_i(osc_in_i), .osc_out_i(osc_out_i),
    .gpio_in_drive(gpio_in_drive), .gpio_out_drive(gpio_out_drive),
    .osc_in_pin(osc_in_pin), .osc_out_pin(osc_out_pin),
    .osc_in_gpio(osc_in_gpio), .osc_out_gpio(osc_out_gpio), .sys_clk_tick(sys_clk_tick),
    .amp_gain(amp_gain), .amp_enable(amp_enable), .int_osc_enable(int_osc_enable),
    .int_range_high(int_range_high), .irq(irq)
  );

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // External clock source: one rising edge every two bus cycles.
  always @(posedge pclk) begin
    ext_clk <= ~ext_clk;
  end

  task automatic close_out;
    begin
      $display("Checks %0d, mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
        $display("Result: passed");
      end else begin
        $display("Result: failed");
      end
      $finish;
    end
  endtask : close_out

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
        @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    begin
      apb(1'b0, a, 32'h0000_0000, q, e);
      `OSP_CHK(q, exp)
    end
  endtask : rd_chk

  task automatic do_reset(input logic [2:0] m, input logic r);
    begin
      presetn <= 1'b0;
      cfg_clock_source <= m;
      cfg_high_range <= r;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (24) @(posedge pclk);
    end
  endtask : do_reset

  // A 64-cycle window is a whole number of every expected period, so counts are exact.
  task automatic count_edges(output int t, output int r);
    logic prev;
    begin
      t = 0;
      r = 0;
      prev = osc_out_pin.o;
      repeat (64) begin
        @(posedge pclk);
        if (sys_clk_tick === 1'b1) t++;
        if (osc_out_pin.o === 1'b1 && prev === 1'b0) r++;
        prev = osc_out_pin.o;
      end
    end
  endtask : count_edges

  task automatic test_modes;
    logic [2:0] m;
    logic [1:0] g;
    int t, r, et;
    begin
      for (int i = 0; i < 8; i++) begin
        m = 3'(i + 6);
        do_reset(m, i[0]);
        g = (m == MODE_LOW_POWER_RES) ? GAIN_LOW : (m == MODE_MEDIUM_GAIN_RES) ? GAIN_MEDIUM :
            (m == MODE_HIGH_GAIN_RES) ? GAIN_HIGH : GAIN_OFF;
        `OSP_CHK(amp_gain, g)
        `OSP_CHK(amp_enable, m < 3'h3)
        `OSP_CHK(int_osc_enable, m == 3'h4 || m == 3'h5)
        `OSP_CHK(int_range_high, i[0])
        `OSP_CHK(osc_in_pin.oe, m == 3'h4 || m == 3'h5)
        `OSP_CHK(osc_out_pin.oe, m >= MODE_EXT_CLOCK)
        if (m != 3'h5 && m != 3'h7) `OSP_CHK(osc_out_gpio, m < 3'h3)
        if (m == 3'h4 || m == 3'h5) `OSP_CHK(osc_in_gpio, 1'b1)
        count_edges(t, r);
        et = (m >= 3'h6 || m < 3'h3) ? 64 : 32;
        `OSP_CHK(t, et)
        `OSP_CHK(r, (m == 3'h5 || m == 3'h7) ? et / 4 : 0)
        rd_chk(ADDR_OSC_CTRL, 32'h0000_0020);
        rd_chk(ADDR_CLK_INFO, {27'h0, 1'b1, i[0], m});
        wr(ADDR_OSC_CTRL, 32'hffff_ffff);
        rd_chk(ADDR_OSC_CTRL, 32'h0000_0030);
      end
      $display("Test modes done");
    end
  endtask : test_modes

  task automatic test_postscaler;
    int t, r;
    begin
      for (int c = 0; c < 4; c++) begin
        wr(ADDR_OSC_CTRL, {26'h0, c[1:0], 4'h0});
        repeat (24) @(posedge pclk);
        count_edges(t, r);
        `OSP_CHK(t, 64 >> (3 - c))
        `OSP_CHK(r, (64 >> (3 - c)) / 4)
      end
      $display("Test postscaler done");
    end
  endtask : test_postscaler

  task automatic test_status;
    logic [31:0] q;
    logic e;
    begin
      wr(ADDR_INT_MASK, 32'h0000_0003);
      lock_raw <= 1'b1;
      repeat (8) @(posedge pclk);
      rd_chk(ADDR_INT_STATUS, 32'h0000_0001);
      `OSP_CHK(irq, 1'b1)
      rd_chk(ADDR_OSC_CTRL, 32'h0000_0038);
      wr(ADDR_INT_STATUS, 32'h0000_0001);
      repeat (2) @(posedge pclk);
      rd_chk(ADDR_INT_STATUS, 32'h0000_0000);
      `OSP_CHK(irq, 1'b0)
      wr(ADDR_INT_MASK, 32'h0000_0000);
      stable_raw <= 1'b1;
      repeat (8) @(posedge pclk);
      rd_chk(ADDR_INT_STATUS, 32'h0000_0002);
      `OSP_CHK(irq, 1'b0)
      rd_chk(ADDR_OSC_CTRL, 32'h0000_003c);
      wr(ADDR_INT_MASK, 32'h0000_0002);
      repeat (2) @(posedge pclk);
      `OSP_CHK(irq, 1'b1)
      wr(ADDR_INT_STATUS, 32'h0000_0002);
      repeat (2) @(posedge pclk);
      `OSP_CHK(irq, 1'b0)
      apb(1'b0, 12'h010, 32'h0000_0000, q, e);
      `OSP_CHK({e, q}, 33'h0_0000_0000 | 33'h1_0000_0000)
      apb(1'b1, 12'h010, 32'h0000_0000, q, e);
      `OSP_CHK(e, 1'b1)
      rd_chk(ADDR_OSC_CTRL, 32'h0000_003c);
      $display("Test status done");
    end
  endtask : test_status

  initial begin
    err_total = 0;
    num_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    cfg_clock_source = MODE_LOW_POWER_RES;
    cfg_high_range = 1'b0;
    int_osc_tick = 1'b1;
    rc_osc_tick = 1'b1;
    resonator_tick = 1'b1;
    lock_raw = 1'b0;
    stable_raw = 1'b0;
    ext_clk = 1'b0;
    gpio_in_drive = '{o: 1'b1, oe: 1'b1};
    gpio_out_drive = '{o: 1'b0, oe: 1'b1};
    @(posedge pclk);
    test_modes();
    test_postscaler();
    test_status();
    close_out();
  end

  // The tests need roughly 1,250 cycles; this margin only cuts a hang short.
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    close_out();
  end

endmodule : osp_osc_ctrl_bench

`default_nettype wire
